// ### adc_clock_divider_and_power_down.v
// Sample-clock divider with sync realignment, duty stabilizer model and
// power-down / standby sequencing for a quad pipelined converter.
// Assumes sync_in and power_down_pin are synchronous to clk; registers are
// written and read over the serial control port's internal access strobes.
`include "adc_clk_pd_regs.vh"

// Contract
// R1 - Divide the input clock by an integer ratio from one to eight.
// R2 - The sync input realigns the internal clock divider.
// R3 - Control bits pick realign on every sync or first sync after write.
// R4 - An accepted sync returns the divider counter to its initial state.
// R5 - Enabled stabilizer regenerates the falling edge for nominally even duty.
// R6 - Stabilizer is not trusted to lock below about twenty megahertz.
// R7 - Allow one and a half microseconds to relock after a rate change.
// R8 - Each sample is taken on the internal clock's rising edge.
// R9 - Power-down is entered by the serial port or a high pin.
// R10 - Powered down, serial data and clock output drivers go high-impedance.
// R11 - Driving the power-down pin low returns to normal conversion.
// R12 - Power-down switches off reference, buffer, bias and internal clock.
// R13 - Wake-up delay grows in proportion to time spent powered down.
// R14 - Software selects full power-down or standby as the low-power state.
// R15 - Standby keeps the reference circuitry powered for faster wake-up.
// R16 - One-shot mode ignores later syncs until the control is rewritten.
module adc_clock_divider_and_power_down #(
  parameter WAKE_W = 16
) (
  input wire clk, // Input sample clock, 25 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire reg_wr_en, // Register write strobe
  input wire reg_rd_en, // Register read strobe
  input wire [`REG_ADDR_W-1:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Register write data
  output reg [7:0] reg_rdata_r, // Read data, valid cycle after read strobe
  input wire sync_in, // External divider sync
  input wire power_down_pin, // High requests power-down
  output reg int_clk_r, // Internal divided sample clock level
  output reg sample_strobe_r, // One-cycle pulse at internal rising edge
  output reg dcs_locked_r, // Duty stabilizer locked
  output reg out_drv_oe_r, // Serial data and clock drivers enabled
  output reg ref_en_r, // Reference powered
  output reg ref_buf_en_r, // Reference buffer powered
  output reg bias_en_r, // Bias networks powered
  output reg clk_run_r, // Internal clock running
  output reg conv_valid_r // Output data valid after wake-up
);
  localparam integer RELOCK_CYC =
    (`DCS_RELOCK_NS * `CLK_FREQ_KHZ + 999999) / 1000000;
  localparam [5:0] RELOCK_MAX = RELOCK_CYC[5:0];

  localparam [2:0] PS_RUN = 3'b001;
  localparam [2:0] PS_DOWN = 3'b010;
  localparam [2:0] PS_WAKE = 3'b100;

  reg [7:0] sync_ctrl_r;
  reg [7:0] power_mode_r;
  reg [7:0] duty_ctrl_r;
  reg [7:0] clk_div_r;
  reg armed_r;
  reg sync_d_r;
  reg [2:0] div_cnt_r;
  reg [2:0] div_cnt_nxt;
  reg [2:0] pstate_r;
  reg [2:0] pstate_nxt;
  reg dcs_en_d_r;
  reg [WAKE_W-1:0] wake_target_r;
  reg [7:0] rdata_nxt;

  wire wr_sync = reg_wr_en && (reg_addr == `REG_DIV_SYNC_CTRL);
  wire wr_div = reg_wr_en && (reg_addr == `REG_CLK_DIV);
  wire pd_req = power_down_pin | power_mode_r[`PM_PD_BIT];
  wire standby = power_mode_r[`PM_STANDBY_BIT];
  wire dcs_en = duty_ctrl_r[`DUTY_STAB_EN_BIT];
  wire [2:0] ratio_m1 = clk_div_r[`DIV_RATIO_MSB:0];
  wire [3:0] ratio = {1'b0, ratio_m1} + 4'h1;
  wire sync_rise = sync_in & ~sync_d_r;
  wire sync_take = sync_rise && sync_ctrl_r[`SYNC_EN_BIT] &&
    (!sync_ctrl_r[`SYNC_ONESHOT_BIT] || armed_r);
  wire in_down = (pstate_r == PS_DOWN);
  wire [3:0] high_len = dcs_en ? ((ratio + 4'h1) >> 1) : 4'h1;
  // Divided rate below the loop's floor never reports lock
  wire [31:0] div_khz = `CLK_FREQ_KHZ / ratio;
  wire lockable = (div_khz >= `DCS_MIN_KHZ);
  wire relock_clr;
  wire relock_done;
  // Only the relock counter's done flag matters; its count stays internal
  wire [WAKE_W-1:0] pd_time;
  wire [WAKE_W-1:0] wake_cnt;
  wire wake_done = (wake_cnt >= wake_target_r);

  // Registers
  always @(posedge clk) begin
    if (!rst_n) begin
      sync_ctrl_r <= `RST_DIV_SYNC_CTRL;
      power_mode_r <= `RST_POWER_MODE;
      duty_ctrl_r <= `RST_DUTY_CTRL;
      clk_div_r <= `RST_CLK_DIV;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `REG_DIV_SYNC_CTRL: sync_ctrl_r <= reg_wdata; // R3
        `REG_POWER_MODE: power_mode_r <= reg_wdata; // R14
        `REG_DUTY_CTRL: duty_ctrl_r <= reg_wdata;
        `REG_CLK_DIV: clk_div_r <= reg_wdata; // R1
        default: ;
      endcase
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `REG_DIV_SYNC_CTRL: rdata_nxt = sync_ctrl_r;
      `REG_POWER_MODE: rdata_nxt = power_mode_r;
      `REG_DUTY_CTRL: rdata_nxt = duty_ctrl_r;
      `REG_CLK_DIV: rdata_nxt = clk_div_r;
      `REG_BLOCK_STATUS: begin
        rdata_nxt[`ST_LOCKED_BIT] = dcs_locked_r;
        rdata_nxt[`ST_PD_BIT] = in_down;
        rdata_nxt[`ST_VALID_BIT] = conv_valid_r;
        rdata_nxt[`ST_ARMED_BIT] = armed_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // Sync detection; a write in the same cycle as a sync re-arms, since that
  // sync did not come after the write
  always @(posedge clk) begin
    if (!rst_n) begin
      sync_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      sync_d_r <= sync_in; // R2
      if (wr_sync) begin
        armed_r <= 1'b1; // R16
      end else if (sync_take) begin
        armed_r <= 1'b0; // R16
      end
    end
  end

  // Divider
  always @* begin
    div_cnt_nxt = div_cnt_r;
    if (in_down || sync_take || wr_div) begin
      div_cnt_nxt = 3'h0; // R4
    end else if (div_cnt_r >= ratio_m1) begin
      div_cnt_nxt = 3'h0; // R1
    end else begin
      div_cnt_nxt = div_cnt_r + 3'h1; // R1
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_r <= 3'h0;
      int_clk_r <= 1'b0;
      sample_strobe_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      // High time of half the period, rounded up, when stabilized, else one input cycle
      int_clk_r <= !in_down && ({1'b0, div_cnt_nxt} < high_len); // R5 R12
      sample_strobe_r <= !in_down && (div_cnt_nxt == 3'h0); // R8 R12
    end
  end

  // Any change of divided rate, stabilizer enable or clock restart relocks
  always @(posedge clk) begin
    if (!rst_n) begin
      dcs_en_d_r <= 1'b0;
      dcs_locked_r <= 1'b0;
    end else begin
      dcs_en_d_r <= dcs_en;
      dcs_locked_r <= dcs_en && lockable && relock_done && !relock_clr; // R6
    end
  end

  assign relock_clr = wr_div || (dcs_en != dcs_en_d_r) || in_down; // R7

  sat_counter #(.W(6), .MAX(RELOCK_MAX)) u_relock (
    .clk(clk),
    .rst_n(rst_n),
    .clr(relock_clr),
    .inc(1'b1),
    .count(),
    .at_max(relock_done)
  );

  // Power sequencing
  always @* begin
    pstate_nxt = pstate_r;
    case (pstate_r)
      PS_RUN: if (pd_req) pstate_nxt = PS_DOWN; // R9
      PS_DOWN: if (!pd_req) pstate_nxt = PS_WAKE; // R11
      PS_WAKE: begin
        if (pd_req) begin
          pstate_nxt = PS_DOWN;
        end else if (wake_done) begin
          pstate_nxt = PS_RUN;
        end
      end
      default: pstate_nxt = PS_DOWN;
    endcase
  end

  // Charge lost grows with time down; standby keeps the reference up so
  // the wait is a smaller share of that time
  always @(posedge clk) begin
    if (!rst_n) begin
      pstate_r <= PS_RUN;
      wake_target_r <= {WAKE_W{1'b0}};
    end else begin
      pstate_r <= pstate_nxt;
      if (in_down) begin
        wake_target_r <= standby ? (pd_time >> `WAKE_SHIFT_STANDBY)
          : (pd_time >> `WAKE_SHIFT_FULL); // R13 R15
      end
    end
  end

  sat_counter #(.W(WAKE_W)) u_pd_time (
    .clk(clk),
    .rst_n(rst_n),
    .clr(pstate_r == PS_RUN),
    .inc(in_down),
    .count(pd_time),
    .at_max()
  );

  sat_counter #(.W(WAKE_W)) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .clr(pstate_r != PS_WAKE),
    .inc(1'b1),
    .count(wake_cnt),
    .at_max()
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      out_drv_oe_r <= 1'b0;
      ref_en_r <= 1'b0;
      ref_buf_en_r <= 1'b0;
      bias_en_r <= 1'b0;
      clk_run_r <= 1'b0;
      conv_valid_r <= 1'b0;
    end else begin
      out_drv_oe_r <= (pstate_nxt != PS_DOWN); // R10
      ref_en_r <= (pstate_nxt != PS_DOWN) || standby; // R12 R15
      ref_buf_en_r <= (pstate_nxt != PS_DOWN) || standby; // R12 R15
      bias_en_r <= (pstate_nxt != PS_DOWN); // R12
      clk_run_r <= (pstate_nxt != PS_DOWN); // R12
      conv_valid_r <= (pstate_nxt == PS_RUN); // R13
    end
  end
endmodule // adc_clock_divider_and_power_down

// ### adc_clk_pd_regs.vh
// Register offsets, field positions, reset values and timing figures for
// the sample-clock divider and power-down block.
// Assumes an 8-bit register port with a 13-bit register address.
`ifndef ADC_CLK_PD_REGS_VH
`define ADC_CLK_PD_REGS_VH

`define REG_ADDR_W 13
`define REG_POWER_MODE 13'h008
`define REG_DUTY_CTRL 13'h009
`define REG_BLOCK_STATUS 13'h00A
`define REG_CLK_DIV 13'h00B
`define REG_DIV_SYNC_CTRL 13'h109

`define SYNC_EN_BIT 0
`define SYNC_ONESHOT_BIT 1
`define PM_PD_BIT 0
`define PM_STANDBY_BIT 1
`define DUTY_STAB_EN_BIT 0
`define DIV_RATIO_MSB 2

`define ST_LOCKED_BIT 0
`define ST_PD_BIT 1
`define ST_VALID_BIT 2
`define ST_ARMED_BIT 3

`define RST_DIV_SYNC_CTRL 8'h00
`define RST_POWER_MODE 8'h00
`define RST_DUTY_CTRL 8'h01
`define RST_CLK_DIV 8'h00

`define CLK_FREQ_KHZ 25000
`define DCS_MIN_KHZ 20000
`define DCS_RELOCK_NS 1500
`define DIV_MAX 8

`define WAKE_SHIFT_FULL 4
`define WAKE_SHIFT_STANDBY 6

`endif

// ### sat_counter.v
// Saturating up-counter with synchronous clear.
// Assumes one clock and an active-low synchronous reset.
module sat_counter #(
  parameter W = 8,
  parameter [W-1:0] MAX = {W{1'b1}}
) (
  input wire clk, // Clock
  input wire rst_n, // Synchronous reset, active low
  input wire clr, // Return count to zero
  input wire inc, // Count one step
  output reg [W-1:0] count, // Current count
  output wire at_max // Count has reached MAX
);
  assign at_max = (count >= MAX);

  always @(posedge clk) begin
    if (!rst_n || clr) begin
      count <= {W{1'b0}};
    end else if (inc && !at_max) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sat_counter

// ### adc_clk_pd_chk.sv
// Port checker for the clock divider and power-down block.
// Assumes the block's port names; bound into every instance.
module adc_clk_pd_chk (
  input wire clk, // Clock
  input wire rst_n, // Reset
  input wire reg_wr_en, // Write
  input wire [12:0] reg_addr, // Address
  input wire [7:0] reg_wdata, // Data
  input wire sync_in, // Sync
  input wire power_down_pin, // Pin
  input wire int_clk_r, // Int clock
  input wire sample_strobe_r, // Strobe
  input wire dcs_locked_r, // Lock
  input wire out_drv_oe_r, // Drivers
  input wire ref_en_r, // Ref
  input wire ref_buf_en_r, // Buffer
  input wire bias_en_r, // Bias
  input wire clk_run_r, // Running
  input wire conv_valid_r // Valid
);
  timeunit 1ns;
  timeprecision 1ns;
  reg pd_r;
  reg [1:0] sc_r;
  reg [2:0] dm_r;
  // Mirrors of written control bits, so no read traffic is needed
  always @(posedge clk) begin
    if (!rst_n) begin
      pd_r <= 1'b0;
      sc_r <= 2'h0;
      dm_r <= 3'h0;
    end else if (reg_wr_en) begin
      if (reg_addr == 13'h008)
        pd_r <= reg_wdata[0];
      if (reg_addr == 13'h109)
        sc_r <= reg_wdata[1:0];
      if (reg_addr == 13'h00B)
        dm_r <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pd_entry: assert property ((power_down_pin || pd_r) |=> !out_drv_oe_r)
    else $error("drivers on while down");
  a_wake_drivers: assert property (!power_down_pin && !pd_r |=> out_drv_oe_r)
    else $error("no wake");
  a_down_all_off: assert property (!out_drv_oe_r |-> !bias_en_r && !clk_run_r
    && !conv_valid_r) else $error("block on while drivers off");
  a_ref_on_run: assert property (out_drv_oe_r |-> ref_en_r && ref_buf_en_r)
    else $error("reference off while running");
  a_strobe_stop: assert property (!clk_run_r && !$past(clk_run_r)
    |-> !sample_strobe_r) else $error("strobe while stopped");
  a_strobe_high: assert property (sample_strobe_r |-> int_clk_r)
    else $error("strobe with clock low");
  a_sync_realign: assert property ($rose(sync_in) && sc_r == 2'h1 && clk_run_r
    && !power_down_pin && !pd_r && !reg_wr_en |=> sample_strobe_r)
    else $error("sync not realigned");
  a_ratio_gap: assert property (disable iff (!rst_n || sync_in || reg_wr_en)
    sample_strobe_r && dm_r == 3'h7 |=> !sample_strobe_r [*6])
    else $error("strobe early at ratio eight");
  a_dcs_rate: assert property (dm_r != 3'h0 |=> !dcs_locked_r)
    else $error("lock at low rate");
  a_relock_wait: assert property (!out_drv_oe_r |=> !dcs_locked_r [*8])
    else $error("lock too soon");
  c_standby: cover property (!out_drv_oe_r && ref_en_r);
  c_wake: cover property ($rose(conv_valid_r));
  c_lock: cover property ($rose(dcs_locked_r));
endmodule // adc_clk_pd_chk

bind adc_clock_divider_and_power_down adc_clk_pd_chk chk (.clk, .rst_n,
  .reg_wr_en, .reg_addr, .reg_wdata, .sync_in, .power_down_pin, .int_clk_r,
  .sample_strobe_r, .dcs_locked_r, .out_drv_oe_r, .ref_en_r, .ref_buf_en_r,
  .bias_en_r, .clk_run_r, .conv_valid_r);

// ### sync_source.sv
// Far side: system sync driver and power-down pin source.
// Assumes calls come just after a clock edge.
module sync_source (
  input wire clk, // Sample clock
  output logic sync_in, // Sync to block
  output logic power_down_pin // Power-down request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sync_in = 1'b0;
    power_down_pin = 1'b0;
  end
  // One-cycle pulse; back-to-back calls leave no low cycle between two events
  task automatic pulse_sync();
    sync_in = 1'b1;
    @(posedge clk) #5;
    sync_in = 1'b0;
  endtask
  task automatic set_pd(input logic lvl);
    power_down_pin = lvl;
  endtask
endmodule // sync_source

// ### testbench.sv
// Self-checking bench for the divider and power-down block.
// Assumes the checker and sync_source are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [12:0] reg_addr = 13'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic rd_d = 1'b0;
  logic [7:0] d;
  logic [7:0] exp_q[$];
  logic [12:0] adr_t[5] = '{13'h109, 13'h008, 13'h009, 13'h00B, 13'h1FFF};
  logic [7:0] rst_t[5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  wire [7:0] reg_rdata_r;
  wire sync_in, power_down_pin, int_clk_r, sample_strobe_r, dcs_locked_r;
  wire out_drv_oe_r, ref_en_r, ref_buf_en_r, bias_en_r, clk_run_r;
  wire conv_valid_r;
  int miscompares = 0;
  int compares = 0;
  int n;
  initial forever #20 clk = ~clk;
  sync_source src (.clk, .sync_in, .power_down_pin);
  adc_clock_divider_and_power_down #(.WAKE_W(8)) dut (.clk, .rst_n,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_r, .sync_in,
    .power_down_pin, .int_clk_r, .sample_strobe_r, .dcs_locked_r,
    .out_drv_oe_r, .ref_en_r, .ref_buf_en_r, .bias_en_r, .clk_run_r,
    .conv_valid_r);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    tick(1);
  endtask
  // Read data is registered, so it is judged one edge after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd_en;
    if (rd_d)
      check(reg_rdata_r, exp_q.pop_front());
  end
  task automatic wait_for(input logic val);
    n = 0;
    while ((val ? conv_valid_r : sample_strobe_r) !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // Sync lands one cycle after a strobe, where no strobe would fall
  task automatic try_sync(input logic want);
    wait_for(1'b0);
    tick(1);
    src.pulse_sync();
    check({7'h00, sample_strobe_r}, {7'h00, want});
  endtask
  // High time of the divided clock, counted from one internal rising edge
  task automatic high_time(input logic [7:0] want);
    wait_for(1'b0);
    n = 0;
    while (int_clk_r === 1'b1 && n < 9) begin
      tick(1);
      n++;
    end
    check(8'(n), want);
  endtask
  initial begin
    n = $urandom(73);
    tick(3);
    rst_n = 1'b1;
    foreach (adr_t[i]) rd(adr_t[i], rst_t[i]);
    d = 8'($urandom);
    wr(13'h109, d);
    wr(13'h1FFF, d);
    rd(13'h109, d);
    rd(13'h1FFF, 8'h00);
    $display("registers done");
    for (int r = 1; r <= 8; r++) begin
      wr(13'h00B, 8'(r - 1));
      wait_for(1'b0);
      tick(1);
      wait_for(1'b0);
      check(8'(n + 1), 8'(r));
    end
    high_time(8'h04);
    wr(13'h009, 8'h00);
    high_time(8'h01);
    wr(13'h009, 8'h01);
    check({7'h00, dcs_locked_r}, 8'h00);
    wr(13'h00B, 8'h00);
    tick(30);
    check({7'h00, dcs_locked_r}, 8'h00);
    tick(10);
    check({7'h00, dcs_locked_r}, 8'h01);
    $display("divider done");
    wr(13'h00B, 8'h03);
    wr(13'h109, 8'h01);
    try_sync(1'b1);
    wr(13'h109, 8'h00);
    try_sync(1'b0);
    wr(13'h109, 8'h03);
    try_sync(1'b1);
    try_sync(1'b0);
    wr(13'h109, 8'h03);
    try_sync(1'b1);
    $display("sync done");
    for (int k = 1; k <= 2; k++) begin
      src.set_pd(1'b1);
      tick(64 * k);
      check({6'h00, out_drv_oe_r, ref_en_r}, 8'h00);
      src.set_pd(1'b0);
      tick(1);
      check({7'h00, out_drv_oe_r}, 8'h01);
      wait_for(1'b1);
      check(8'(n >= 4 * k && n <= 4 * k + 4), 8'h01);
    end
    wr(13'h008, 8'h03);
    tick(2);
    check({6'h00, out_drv_oe_r, ref_en_r}, 8'h01);
    rd(13'h00A, 8'h02);
    wr(13'h008, 8'h01);
    tick(2);
    check({6'h00, out_drv_oe_r, ref_buf_en_r}, 8'h00);
    wr(13'h008, 8'h00);
    wait_for(1'b1);
    rd(13'h00A, 8'h04);
    $display("power done");
    // Reset in mid-run must restore the duty control and restart running
    wr(13'h009, 8'h00);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    rd(13'h009, 8'h01);
    rd(13'h00A, 8'h04);
    $display("reset done");
    give_verdict();
  end
endmodule // testbench
